// ---- logic/tcu_pkg.sv ----
/*
 * Constants shared by the timer capture unit: register addresses,
 * control field positions and reset values.
 * Assumes a 32-bit word bus with byte addresses.
 */
package tcu_pkg;

	// ********************************************************
	// Widths
	// ********************************************************
	localparam int WORD_W = 32;
	localparam int CHANNELS = 4;
	localparam int PIN_CAPS = 3;
	localparam int CC_USED_W = 12;

	// ********************************************************
	// Register byte addresses
	// ********************************************************
	localparam logic [31:0] CAPTURE_CONTROL_ADDR = 32'h40014028;
	localparam logic [31:0] CAPTURE_VALUE_0_ADDR = 32'h4001402c;
	localparam logic [31:0] CAPTURE_VALUE_1_ADDR = 32'h40014030;
	localparam logic [31:0] CAPTURE_VALUE_2_ADDR = 32'h40014034;
	localparam logic [31:0] CAPTURE_VALUE_3_ADDR = 32'h40014038;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'h40014070;
	localparam logic [31:0] IRQ_MASK_ADDR = 32'h40014074;

	// ********************************************************
	// Control fields, three bits per channel
	// ********************************************************
	localparam int CC_RISE_POS = 0;
	localparam int CC_FALL_POS = 1;
	localparam int CC_IRQ_POS = 2;
	localparam int CC_STRIDE = 3;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [CC_USED_W-1:0] CC_RESET = 12'h000;
	localparam logic [WORD_W-1:0] CAPTURE_RESET = 32'h00000000;
	localparam logic [CHANNELS-1:0] IRQ_STATUS_RESET = 4'h0;
	localparam logic [CHANNELS-1:0] IRQ_MASK_RESET = 4'h0;
	localparam logic [WORD_W-1:0] READ_ZERO = 32'h00000000;

endpackage

// ---- logic/tcu_edge_det.sv ----
/*
 * Edge detector for the capture signals.
 * Assumes the signals are already synchronous to sys_clk.
 */
`timescale 1ns/1ps
module tcu_edge_det #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Sampled signals
	input wire logic [N-1:0] sig,
	// Edge pulses
	output logic [N-1:0] rise,
	output logic [N-1:0] fall
);
	import tcu_pkg::*;

	logic [N-1:0] prev_reg, prev_next;
	logic seen_reg, seen_next;

	// ********************************************************
	// Previous sample
	// ********************************************************

	// The first sample after reset only primes the history, so a level
	// that is already high at reset is not taken for an edge.
	always_comb begin
		prev_next = sig;
		seen_next = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prev_reg <= '0;
			seen_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
			seen_reg <= seen_next;
		end
	end

	// Compare the current level with the previous one every cycle after the first one following reset.
	assign rise = {N{seen_reg}} & sig & ~prev_reg;
	assign fall = {N{seen_reg}} & ~sig & prev_reg;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_edge_compare: assert property (
		seen_reg |-> (rise == (sig & ~$past(sig))) && (fall == (~sig & $past(sig))))
		else $error("Edge pulse does not match sample history.");

endmodule

// ---- logic/tcu_match_out.sv ----
/*
 * Match output selector: each match pin follows either its external
 * match bit or, when set up for PWM, the PWM level.
 * Assumes match bits and PWM levels come from the timer core.
 */
`timescale 1ns/1ps
module tcu_match_out #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Match sources
	input wire logic [N-1:0] external_match_ctrl,
	input wire logic [N-1:0] pwm_output_config,
	input wire logic [N-1:0] pwm_level,
	// Pins
	output logic [N-1:0] match_output_pin
);
	import tcu_pkg::*;

	logic [N-1:0] pin_reg, pin_next;

	// ********************************************************
	// Source select
	// ********************************************************

	// PWM mode overrides the normal external match behaviour.
	always_comb begin
		pin_next = (pwm_output_config & pwm_level) | (~pwm_output_config & external_match_ctrl);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_reg <= '0;
		end else begin
			pin_reg <= pin_next;
		end
	end

	assign match_output_pin = pin_reg;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_pwm_override: assert property (
		1'b1 |=> ((match_output_pin & $past(pwm_output_config)) ==
			($past(pwm_level) & $past(pwm_output_config))))
		else $error("PWM pin does not follow the PWM level.");

endmodule

// ---- logic/tcu_capture_top.sv ----
/*
 * Capture unit of a 32-bit counter/timer with a Wishbone slave.
 * Channels 0 to 2 watch capture pins, channel 3 the comparator output.
 * Assumes all inputs are synchronous to sys_clk and the timer counter
 * is supplied by the timer core.
 */
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
module tcu_capture_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [tcu_pkg::WORD_W-1:0] wb_dat_i,
	output logic [tcu_pkg::WORD_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Timer core
	input wire logic [tcu_pkg::WORD_W-1:0] timer_count,
	// Capture sources
	input wire logic [tcu_pkg::PIN_CAPS-1:0] capture_in,
	input wire logic comparator_out,
	// Match outputs
	input wire logic [tcu_pkg::CHANNELS-1:0] external_match_ctrl,
	input wire logic [tcu_pkg::CHANNELS-1:0] pwm_output_config,
	input wire logic [tcu_pkg::CHANNELS-1:0] pwm_level,
	output logic [tcu_pkg::CHANNELS-1:0] match_output_pin,
	// Interrupt
	output logic irq
);
	import tcu_pkg::*;

	// ********************************************************
	// Declarations
	// ********************************************************
	logic [CC_USED_W-1:0] capture_control_reg, capture_control_next;
	logic [CHANNELS-1:0] irq_status_reg, irq_status_next;
	logic [CHANNELS-1:0] irq_mask_reg, irq_mask_next;
	logic [WORD_W-1:0] captured_value_reg [CHANNELS];
	logic [WORD_W-1:0] captured_value_next [CHANNELS];
	logic ack_reg, ack_next;
	logic [WORD_W-1:0] rdata_reg, rdata_next;
	logic [CHANNELS-1:0] cap_sig;
	logic [CHANNELS-1:0] rise;
	logic [CHANNELS-1:0] fall;
	logic [CHANNELS-1:0] load;
	logic [CHANNELS-1:0] irq_set;
	logic [CHANNELS-1:0] irq_clear;
	logic req;
	logic wr_fire;

	// Picks one control bit of one channel.
	function automatic logic cc_bit(input logic [CC_USED_W-1:0] cc, input int ch, input int pos);
		return cc[ch * CC_STRIDE + pos];
	endfunction

	// ********************************************************
	// Edge detection
	// ********************************************************

	// Channel 3 is fed by the comparator, the others by pins.
	assign cap_sig = {comparator_out, capture_in};

	tcu_edge_det #(
		.N(CHANNELS)
	) u_edge (
		.sys_clk(sys_clk),
		.reset(reset),
		.sig(cap_sig),
		.rise(rise),
		.fall(fall)
	);

	// ********************************************************
	// Capture
	// ********************************************************

	// A channel loads on each enabled edge; both enables give both edges.
	always_comb begin
		for (int ch = 0; ch < CHANNELS; ch++) begin
			load[ch] = (rise[ch] & cc_bit(capture_control_reg, ch, CC_RISE_POS))
				| (fall[ch] & cc_bit(capture_control_reg, ch, CC_FALL_POS));
			irq_set[ch] = load[ch] & cc_bit(capture_control_reg, ch, CC_IRQ_POS);
		end
	end

	// The timer count of the edge cycle is copied into the channel.
	always_comb begin
		for (int ch = 0; ch < CHANNELS; ch++) begin
			captured_value_next[ch] = load[ch] ? timer_count : captured_value_reg[ch];
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int ch = 0; ch < CHANNELS; ch++) begin
			if (reset) begin
				captured_value_reg[ch] <= CAPTURE_RESET;
			end else begin
				captured_value_reg[ch] <= captured_value_next[ch];
			end
		end
	end

	// ********************************************************
	// Wishbone slave
	// ********************************************************

	// Ack comes one cycle after the request and drops the cycle after.
	// A write takes effect at the edge where the master sees ack.
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_fire = req & wb_we_i & ack_reg;

	always_comb begin
		ack_next = req & ~ack_reg;
		rdata_next = rdata_reg;
		if (req && !ack_reg) begin
			unique case (wb_adr_i)
				CAPTURE_CONTROL_ADDR: rdata_next = {20'h00000, capture_control_reg};
				CAPTURE_VALUE_0_ADDR: rdata_next = captured_value_reg[0];
				CAPTURE_VALUE_1_ADDR: rdata_next = captured_value_reg[1];
				CAPTURE_VALUE_2_ADDR: rdata_next = captured_value_reg[2];
				CAPTURE_VALUE_3_ADDR: rdata_next = captured_value_reg[3];
				IRQ_STATUS_ADDR: rdata_next = {28'h0000000, irq_status_reg};
				IRQ_MASK_ADDR: rdata_next = {28'h0000000, irq_mask_reg};
				default: rdata_next = READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
			rdata_reg <= READ_ZERO;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// ********************************************************
	// Control and mask registers
	// ********************************************************

	// Only bits 11:0 exist; upper bits written are dropped and read zero.
	always_comb begin
		capture_control_next = capture_control_reg;
		irq_mask_next = irq_mask_reg;
		if (wr_fire && wb_adr_i == CAPTURE_CONTROL_ADDR) begin
			if (wb_sel_i[0]) begin
				capture_control_next[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				capture_control_next[11:8] = wb_dat_i[11:8];
			end
		end
		if (wr_fire && wb_adr_i == IRQ_MASK_ADDR && wb_sel_i[0]) begin
			irq_mask_next = wb_dat_i[CHANNELS-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			capture_control_reg <= CC_RESET;
			irq_mask_reg <= IRQ_MASK_RESET;
		end else begin
			capture_control_reg <= capture_control_next;
			irq_mask_reg <= irq_mask_next;
		end
	end

	// ********************************************************
	// Interrupt status
	// ********************************************************

	// Writing one clears a bit; a capture in the same cycle wins.
	always_comb begin
		irq_clear = '0;
		if (wr_fire && wb_adr_i == IRQ_STATUS_ADDR && wb_sel_i[0]) begin
			irq_clear = wb_dat_i[CHANNELS-1:0];
		end
		irq_status_next = (irq_status_reg & ~irq_clear) | irq_set;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_status_reg <= IRQ_STATUS_RESET;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	// Level output while any unmasked status bit is set.
	assign irq = |(irq_status_reg & irq_mask_reg);

	// ********************************************************
	// Match pins
	// ********************************************************
	tcu_match_out #(
		.N(CHANNELS)
	) u_match (
		.sys_clk(sys_clk),
		.reset(reset),
		.external_match_ctrl(external_match_ctrl),
		.pwm_output_config(pwm_output_config),
		.pwm_level(pwm_level),
		.match_output_pin(match_output_pin)
	);

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_rise_capture: assert property (
		(rise[3] && capture_control_reg[9]) |=> captured_value_reg[3] == $past(timer_count))
		else $error("Comparator rise did not capture the count.");

	a_fall_capture: assert property (
		(fall[3] && capture_control_reg[10]) |=> captured_value_reg[3] == $past(timer_count))
		else $error("Comparator fall did not capture the count.");

	a_fall_blocked: assert property (
		(fall[3] && !capture_control_reg[10]) |=> $stable(captured_value_reg[3]))
		else $error("Disabled fall still captured.");

	a_irq_raise: assert property (
		(rise[3] && capture_control_reg[9] && capture_control_reg[11]) |=> irq_status_reg[3])
		else $error("Capture with interrupt enable set no status.");

	a_irq_quiet: assert property (
		(!irq_status_reg[3] && !capture_control_reg[11]) |=> !irq_status_reg[3])
		else $error("Status set with interrupt enable clear.");

	a_cap_hold: assert property (
		(!rise[0] && !fall[0]) |=> $stable(captured_value_reg[0]))
		else $error("Capture register changed without an edge.");

	a_both_edges: assert property (
		(capture_control_reg[4:3] == 2'b11 && (rise[1] || fall[1]))
		|=> captured_value_reg[1] == $past(timer_count))
		else $error("Both-edge mode missed an edge.");

	a_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Ack held longer than one cycle.");

	a_irq_level: assert property (
		(irq_status_reg[2] && irq_mask_reg[2]) |-> irq)
		else $error("Unmasked status did not raise irq.");

	a_rise_blocked: assert property (
		(rise[3] && !capture_control_reg[9]) |=> $stable(captured_value_reg[3]))
		else $error("Disabled rise still captured.");

	a_fall_irq: assert property (
		(fall[3] && capture_control_reg[10] && capture_control_reg[11]) |=> irq_status_reg[3])
		else $error("Fall capture with interrupt enable set no status.");

	a_pin_rise: assert property (
		(rise[0] && capture_control_reg[0]) |=> captured_value_reg[0] == $past(timer_count))
		else $error("Pin rise did not capture the count.");

	a_pin_fall: assert property (
		(fall[2] && capture_control_reg[7]) |=> captured_value_reg[2] == $past(timer_count))
		else $error("Pin fall did not capture the count.");

	a_ack_answer: assert property (
		(req && !ack_reg) |=> wb_ack_o)
		else $error("Request was not acknowledged in the next cycle.");

	a_clear_one: assert property (
		(wr_fire && wb_adr_i == IRQ_STATUS_ADDR && wb_sel_i[0] && wb_dat_i[0] && !irq_set[0]) |=> !irq_status_reg[0])
		else $error("Writing one did not clear the status bit.");

	a_irq_masked: assert property (
		((irq_status_reg & irq_mask_reg) == '0) |-> !irq)
		else $error("Irq raised with no unmasked status.");

	// The reset checks run while reset is high, so they override the default disable.
	a_ctrl_reset: assert property (
		disable iff (1'b0) reset |=> capture_control_reg == CC_RESET && irq_status_reg == IRQ_STATUS_RESET)
		else $error("Control or status not cleared by reset.");

	a_value_reset: assert property (
		disable iff (1'b0) reset |=> captured_value_reg[3] == CAPTURE_RESET)
		else $error("Capture value not cleared by reset.");

endmodule

// ---- tb/tcu_source_model.sv ----
/*
 * Model of the capture sources: three capture pins and the comparator output.
 * Assumes the bench asks for new levels just after a rising edge of sys_clk.
 */
`timescale 1ns/1ps
module tcu_source_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Requested levels and pace
	input wire logic [3:0] want,
	input wire logic slow,
	// Source levels
	output logic [2:0] capture_in,
	output logic comparator_out
);
	logic hold_reg;

	// Levels move on the clock; a slow source only moves every other cycle.
	always @(posedge sys_clk) begin
		if (reset) begin
			hold_reg <= 1'b0;
			{comparator_out, capture_in} <= 4'h0;
		end else begin
			hold_reg <= slow & ~hold_reg;
			if (!hold_reg) begin
				{comparator_out, capture_in} <= want;
			end
		end
	end
endmodule

// ---- tb/timer_capture_unit_tb.sv ----
/*
 * Self-checking bench of the timer capture unit with a behavioural model.
 * Assumes the design acks each Wishbone request within a few cycles.
 */
`timescale 1ns/1ps
module timer_capture_unit_tb;
	import tcu_pkg::*;
	logic sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, comparator_out, irq, slow;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, timer_count, rd;
	logic [3:0] wb_sel_i, external_match_ctrl, pwm_output_config, pwm_level, match_output_pin, want;
	logic [2:0] capture_in;
	logic [31:0] addrs[8];
	int errors, checked, seed, m_ctrl, m_stat, m_mask, m_match, prev, cur, clr;
	logic wr_ack;
	int m_cap[4];
	int tbl[8] = '{0, 32'h200, 32'h400, 32'h600, 32'he00, 32'hb6d, 32'hfff, 32'h492};

	tcu_capture_top dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_count(timer_count), .capture_in(capture_in),
		.comparator_out(comparator_out), .external_match_ctrl(external_match_ctrl),
		.pwm_output_config(pwm_output_config), .pwm_level(pwm_level),
		.match_output_pin(match_output_pin), .irq(irq));
	tcu_source_model src (.sys_clk(sys_clk), .reset(reset), .want(want), .slow(slow),
		.capture_in(capture_in), .comparator_out(comparator_out));

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// The clock runs at 20 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Free-running count and random match sources.
	always @(posedge sys_clk) begin
		timer_count <= timer_count + 32'h1;
		external_match_ctrl <= 4'($random(seed));
		pwm_output_config <= 4'($random(seed));
		pwm_level <= 4'($random(seed));
	end

	// Model of captures, status and match pins, fed by the levels of the closing cycle.
	always @(posedge sys_clk) begin
		m_match = reset ? 0 : int'((pwm_output_config & pwm_level) | (~pwm_output_config & external_match_ctrl));
		cur = int'({comparator_out, capture_in});
		// A write lands at the edge where ack is seen; a capture at that edge beats a clear.
		wr_ack = !reset && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o === 1'b1;
		clr = (wr_ack && wb_adr_i == IRQ_STATUS_ADDR) ? int'(wb_dat_i & 32'hf) : 0;
		m_stat &= ~clr;
		for (int ch = 0; ch < 4; ch++) begin
			if (!reset && cur[ch] != prev[ch] && m_ctrl[3 * ch + (cur[ch] ? 0 : 1)]) begin
				m_cap[ch] = timer_count;
				if (m_ctrl[3 * ch + 2])
					m_stat |= 1 << ch;
			end
		end
		prev = cur;
		if (wr_ack && wb_adr_i == CAPTURE_CONTROL_ADDR)
			m_ctrl = int'(wb_dat_i & 32'hfff);
		if (wr_ack && wb_adr_i == IRQ_MASK_ADDR)
			m_mask = int'(wb_dat_i & 32'hf);
	end

	// Level outputs are compared once they have settled.
	always @(negedge sys_clk) begin
		if (!reset) begin
			check({31'h0, irq}, 32'((m_stat & m_mask) != 0), "irq level");
			check({28'h0, match_output_pin}, 32'(m_match & 15), "match pins");
		end
	end

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			check(32'h0, 32'h1, "ack timeout");
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	function automatic logic [31:0] exp_rd(input int i);
		case (i)
			0: return m_ctrl;
			1, 2, 3, 4: return m_cap[i - 1];
			5: return m_stat;
			6: return m_mask;
			default: return 32'h0;
		endcase
	endfunction

	// Reads every register and one unmapped word.
	task automatic read_all;
		for (int i = 0; i < 8; i++) begin
			wb_xfer(1'b0, addrs[i], 32'h0);
			check(rd, exp_rd(i), "register read");
		end
	endtask

	// Main sequence: reset, then one round per control setting.
	initial begin
		seed = 32'h074b;
		addrs = '{CAPTURE_CONTROL_ADDR, CAPTURE_VALUE_0_ADDR, CAPTURE_VALUE_1_ADDR, CAPTURE_VALUE_2_ADDR,
			CAPTURE_VALUE_3_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR, 32'h40014060};
		{reset, wb_cyc_i, wb_stb_i, wb_we_i, slow} = 5'h10;
		{wb_adr_i, wb_dat_i, want, external_match_ctrl, pwm_output_config, pwm_level} = '0;
		wb_sel_i = 4'hf;
		timer_count = $random(seed);
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		read_all;
		for (int i = 0; i < 8; i++) begin
			wb_xfer(1'b1, CAPTURE_CONTROL_ADDR, tbl[i] & 32'hfff);
			wb_xfer(1'b1, IRQ_MASK_ADDR, i[0] ? ($random(seed) & 32'hf) : 32'hf);
			slow <= i[1];
			repeat (40) begin
				@(posedge sys_clk);
				want <= 4'($random(seed));
			end
			repeat (3) @(posedge sys_clk);
			read_all;
			wb_xfer(1'b1, IRQ_STATUS_ADDR, 32'hf);
			wb_xfer(1'b0, IRQ_STATUS_ADDR, 32'h0);
			check(rd, exp_rd(5), "status after clear");
		end
		test_done;
	end

	// Watchdog well beyond the expected length of the run.
	initial begin
		#1500000;
		errors++;
		test_done;
	end
endmodule
